// ---- design/dgp_top.sv ----
// dgp_top: two gpio ports with latch, direction, lcd mux and standby float
// assumes pins and peripheral signals are synchronous to clk_i
// Operation
// - direction one makes the pin an output driven by the latch bit
// - direction zero disables the driver; pin is an input
// - writes always update the latch; pin sees it only as output
// - ordinary read returns the latch for output pins
// - ordinary read returns the pin level for input pins
// - read-modify-write reads always return the latch
// - enabled peripheral drives the pin; read returns its level
// - peripheral input pins read the pin level; direction should be zero
// - lcd select one with input control set routes the segment output to the first port pin
// - lcd select zero gives the pin to gpio, then input control set
// - reset clears every direction bit, all pins are inputs
// - float bit one in stop or watch floats pins, input held low
// - float bit zero in standby keeps configuration and output level
// - open-drain second port pin releases instead of driving high
// - first port bits 0..7 map to pins; second port bits 0..2
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module dgp_top
  import dgp_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic                    rmw_read_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    standby_i,
  input  wire dgp_periph_s             periph_i,
  input  wire logic [FIRST_WIDTH-1:0]  first_pin_i,
  input  wire logic [SECOND_WIDTH-1:0] second_pin_i,
  output dgp_first_pins_s              first_pins_o,
  output dgp_second_pins_s             second_pins_o,
  output logic [FIRST_WIDTH-1:0]       first_in_o,
  output logic [SECOND_WIDTH-1:0]      second_in_o
);

  logic [FIRST_WIDTH-1:0]  first_latch_q;
  logic [FIRST_WIDTH-1:0]  first_dir_q;
  logic [SECOND_WIDTH-1:0] second_latch_q;
  logic [SECOND_WIDTH-1:0] second_dir_q;
  logic [FIRST_WIDTH-1:0]  lcd_sel_q;
  logic                    in_ctl_q;
  logic                    float_sel_q;
  logic [SECOND_WIDTH-1:0] od_q;
  logic                    ack_q;
  logic [31:0]             rdata_q;
  logic [31:0]             rdata_d;
  logic                    req;
  logic                    wr;
  logic                    float_all;
  logic [FIRST_WIDTH-1:0]  first_pad;
  logic [SECOND_WIDTH-1:0] second_pad;

  // one-wait-state slave: ack rises the cycle after the request, then drops
  assign req       = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr        = req && wb_we_i && wb_sel_i[0];
  assign float_all = standby_i && float_sel_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_dir_q  <= DIR_RESET;
      second_dir_q <= DIR_RESET[SECOND_WIDTH-1:0];
    end else if (wr && wb_adr_i == ADDR_FIRST_DIR) begin
      first_dir_q <= wb_dat_i[FIRST_WIDTH-1:0];
    end else if (wr && wb_adr_i == ADDR_SECOND_DIR) begin
      second_dir_q <= wb_dat_i[SECOND_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_latch_q  <= LATCH_RESET;
      second_latch_q <= LATCH_RESET[SECOND_WIDTH-1:0];
    end else if (wr && wb_adr_i == ADDR_FIRST_LATCH) begin
      first_latch_q <= wb_dat_i[FIRST_WIDTH-1:0];
    end else if (wr && wb_adr_i == ADDR_SECOND_LATCH) begin
      second_latch_q <= wb_dat_i[SECOND_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lcd_sel_q   <= SEL_RESET;
      in_ctl_q    <= 1'b0;
      float_sel_q <= 1'b0;
      od_q        <= OD_RESET;
    end else if (wr && wb_adr_i == ADDR_LCD_SELECT) begin
      lcd_sel_q <= wb_dat_i[FIRST_WIDTH-1:0];
    end else if (wr && wb_adr_i == ADDR_CONTROL) begin
      in_ctl_q    <= wb_dat_i[CTL_IN_CTL_BIT];
      float_sel_q <= wb_dat_i[CTL_FLOAT_BIT];
      if (wb_sel_i[1]) begin
        od_q <= wb_dat_i[CTL_OD_LSB +: SECOND_WIDTH];
      end
    end
  end

  // pin drive per bit; the oe is active low, low means the pin is driven
  // lcd routing needs the input control bit so a half-set mux never drives
  genvar gi;
  generate
    for (gi = 0; gi < FIRST_WIDTH; gi++) begin : g_first
      logic lcd_on;
      assign lcd_on = lcd_sel_q[gi] && in_ctl_q;
      always_comb begin
        first_pins_o.out[gi]  = first_latch_q[gi];
        first_pins_o.oe_n[gi] = !first_dir_q[gi];
        if (lcd_on) begin
          first_pins_o.out[gi]  = periph_i.seg[gi];
          first_pins_o.oe_n[gi] = 1'b0;
        end else if (periph_i.per_oe[gi]) begin
          first_pins_o.out[gi]  = periph_i.per_out[gi];
          first_pins_o.oe_n[gi] = 1'b0;
        end
        if (float_all) begin
          first_pins_o.oe_n[gi] = 1'b1;
        end
      end
      // while driven the pad reflects our own drive, so reads see it
      assign first_pad[gi] = first_pins_o.oe_n[gi] ? first_pin_i[gi]
                                                   : first_pins_o.out[gi];
    end
    for (gi = 0; gi < SECOND_WIDTH; gi++) begin : g_second
      logic drive;
      assign drive = second_dir_q[gi] && !float_all;
      always_comb begin
        second_pins_o.out[gi]  = second_latch_q[gi];
        second_pins_o.oe_n[gi] = !drive;
        if (od_q[gi] && second_latch_q[gi]) begin
          second_pins_o.oe_n[gi] = 1'b1;
        end
      end
      assign second_pad[gi] = second_pins_o.oe_n[gi] ? second_pin_i[gi]
                                                     : second_pins_o.out[gi];
    end
  endgenerate

  // inputs are blocked low while floated, so an open pin cannot leak
  assign first_in_o  = float_all ? '0 : first_pad;
  assign second_in_o = float_all ? '0 : second_pad;

  always_comb begin
    rdata_d = UNMAPPED_READ;
    case (wb_adr_i)
      ADDR_FIRST_LATCH: begin
        if (rmw_read_i) begin
          rdata_d[FIRST_WIDTH-1:0] = first_latch_q;
        end else begin
          rdata_d[FIRST_WIDTH-1:0] = (first_dir_q & first_latch_q)
                                   | (~first_dir_q & first_in_o);
          rdata_d[FIRST_WIDTH-1:0] = (periph_i.per_oe & periph_i.per_out)
                                   | (~periph_i.per_oe
                                      & rdata_d[FIRST_WIDTH-1:0]);
        end
      end
      ADDR_FIRST_DIR: rdata_d[FIRST_WIDTH-1:0] = first_dir_q;
      ADDR_SECOND_LATCH: begin
        if (rmw_read_i) begin
          rdata_d[SECOND_WIDTH-1:0] = second_latch_q;
        end else begin
          rdata_d[SECOND_WIDTH-1:0] = (second_dir_q & second_latch_q)
                                    | (~second_dir_q & second_in_o);
        end
      end
      ADDR_SECOND_DIR: rdata_d[SECOND_WIDTH-1:0] = second_dir_q;
      ADDR_LCD_SELECT: rdata_d[FIRST_WIDTH-1:0] = lcd_sel_q;
      ADDR_CONTROL: begin
        rdata_d[CTL_IN_CTL_BIT]               = in_ctl_q;
        rdata_d[CTL_FLOAT_BIT]                = float_sel_q;
        rdata_d[CTL_OD_LSB +: SECOND_WIDTH]   = od_q;
      end
      default: rdata_d = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= UNMAPPED_READ;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // all checks run on the one clock; reset is named per check
  default clocking cb @(posedge clk_i);
  endclocking

  // level an ordinary first-port read should return with timers off
  logic [FIRST_WIDTH-1:0] first_rd_exp;
  assign first_rd_exp = (first_dir_q & first_latch_q)
                      | (~first_dir_q & first_in_o);

  // bus steps: a request is taken, then answered on the next edge
  sequence s_take;
    req;
  endsequence

  sequence s_answer;
    wb_ack_o;
  endsequence

  sequence s_read_first;
    req && !wb_we_i && !rmw_read_i && wb_adr_i == ADDR_FIRST_LATCH;
  endsequence

  sequence s_rmw_second;
    req && !wb_we_i && rmw_read_i && wb_adr_i == ADDR_SECOND_LATCH;
  endsequence

  a_reset_dir: assert property (
    rst_i |=> (first_dir_q == DIR_RESET) && (second_dir_q == '0))
    else $error("direction not cleared by reset");

  a_float_pins: assert property (disable iff (rst_i)
    float_all |-> (&first_pins_o.oe_n) && (&second_pins_o.oe_n)
                  && first_in_o == '0 && second_in_o == '0)
    else $error("pins not floated in standby");

  a_latch_write: assert property (disable iff (rst_i)
    wr && wb_adr_i == ADDR_FIRST_LATCH |=>
      first_latch_q == $past(wb_dat_i[FIRST_WIDTH-1:0]))
    else $error("latch not updated by write");

  a_dir_write: assert property (disable iff (rst_i)
    wr && wb_adr_i == ADDR_FIRST_DIR |=>
      first_dir_q == $past(wb_dat_i[FIRST_WIDTH-1:0]))
    else $error("direction not updated by write");

  a_second_write: assert property (disable iff (rst_i)
    wr && wb_adr_i == ADDR_SECOND_DIR |=>
      second_dir_q == $past(wb_dat_i[SECOND_WIDTH-1:0]))
    else $error("second direction not updated by write");

  a_rmw_latch: assert property (disable iff (rst_i)
    req && !wb_we_i && rmw_read_i && wb_adr_i == ADDR_FIRST_LATCH |=>
      wb_ack_o && wb_dat_o[FIRST_WIDTH-1:0] == $past(first_latch_q))
    else $error("rmw read did not return latch");

  a_rmw_second: assert property (disable iff (rst_i)
    s_rmw_second |=> s_answer
      ##0 (wb_dat_o[SECOND_WIDTH-1:0] == $past(second_latch_q)))
    else $error("rmw read of second port did not return latch");

  a_plain_read: assert property (disable iff (rst_i)
    s_read_first ##0 (periph_i.per_oe == '0) |=>
      s_answer ##0 (wb_dat_o[FIRST_WIDTH-1:0] == $past(first_rd_exp)))
    else $error("ordinary read returned wrong level");

  a_bus_answer: assert property (disable iff (rst_i)
    s_take |=> s_answer)
    else $error("request not answered on the next edge");

  a_out_drive: assert property (disable iff (rst_i)
    !float_all && first_dir_q[0] && !lcd_sel_q[0] && !periph_i.per_oe[0]
      |-> !first_pins_o.oe_n[0] && first_pins_o.out[0] == first_latch_q[0])
    else $error("output pin not driven from latch");

  a_in_release: assert property (disable iff (rst_i)
    !first_dir_q[1] && !(lcd_sel_q[1] && in_ctl_q) && !periph_i.per_oe[1]
      |-> first_pins_o.oe_n[1])
    else $error("input pin driven");

  a_timer_drive: assert property (disable iff (rst_i)
    !float_all && !(lcd_sel_q[5] && in_ctl_q) && periph_i.per_oe[5]
      |-> !first_pins_o.oe_n[5]
          && first_pins_o.out[5] == periph_i.per_out[5])
    else $error("timer output not driven on its pin");

  a_gpio_release: assert property (disable iff (rst_i)
    !lcd_sel_q[4] && !first_dir_q[4] && !periph_i.per_oe[4]
      |-> first_pins_o.oe_n[4])
    else $error("gpio input pin still driven after lcd release");

  a_hold_level: assert property (disable iff (rst_i)
    standby_i && !float_sel_q && first_dir_q[6]
      && !(lcd_sel_q[6] && in_ctl_q) && !periph_i.per_oe[6]
      |-> !first_pins_o.oe_n[6]
          && first_pins_o.out[6] == first_latch_q[6])
    else $error("output level lost in standby");

  a_od_release: assert property (disable iff (rst_i)
    od_q[2] && second_latch_q[2] |-> second_pins_o.oe_n[2])
    else $error("open drain pin driven high");

  a_second_zero: assert property (disable iff (rst_i)
    req && !wb_we_i && wb_adr_i == ADDR_SECOND_DIR |=>
      wb_dat_o[31:SECOND_WIDTH] == '0)
    else $error("unimplemented bits not zero");

  a_lcd_route: assert property (disable iff (rst_i)
    !float_all && lcd_sel_q[3] && in_ctl_q |->
      !first_pins_o.oe_n[3] && first_pins_o.out[3] == periph_i.seg[3])
    else $error("segment not routed");

  a_ack_pulse: assert property (disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : dgp_top

// ---- design/dgp_pkg.sv ----
// dgp_pkg: register map, field layouts and carriers for the dual gpio block
// assumes a 32-bit classic wishbone slave with word-aligned registers
package dgp_pkg;

  localparam int unsigned FIRST_WIDTH  = 8;
  localparam int unsigned SECOND_WIDTH = 3;

  // byte addresses of the register words
  localparam logic [7:0] ADDR_FIRST_LATCH  = 8'h00;
  localparam logic [7:0] ADDR_FIRST_DIR    = 8'h04;
  localparam logic [7:0] ADDR_SECOND_LATCH = 8'h08;
  localparam logic [7:0] ADDR_SECOND_DIR   = 8'h0c;
  localparam logic [7:0] ADDR_LCD_SELECT   = 8'h10;
  localparam logic [7:0] ADDR_CONTROL      = 8'h14;

  // control register fields
  localparam int unsigned CTL_IN_CTL_BIT = 0;
  localparam int unsigned CTL_FLOAT_BIT  = 1;
  localparam int unsigned CTL_OD_LSB    = 8;

  localparam logic [7:0] DIR_RESET   = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET   = 8'h00;
  localparam logic [2:0] OD_RESET    = 3'h4;

  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef struct packed {
    logic [FIRST_WIDTH-1:0] out;
    logic [FIRST_WIDTH-1:0] oe_n;
  } dgp_first_pins_s;

  typedef struct packed {
    logic [SECOND_WIDTH-1:0] out;
    logic [SECOND_WIDTH-1:0] oe_n;
  } dgp_second_pins_s;

  typedef struct packed {
    logic [FIRST_WIDTH-1:0] seg;
    logic [FIRST_WIDTH-1:0] per_oe;
    logic [FIRST_WIDTH-1:0] per_out;
  } dgp_periph_s;

endpackage : dgp_pkg

// ---- verif/dgp_pad_model.sv ----
// dgp_pad_model: external pads seen by both gpio ports
// assumes no pull resistor, so a released pad shows the outside level
`timescale 1ns/1ps
module dgp_pad_model
  import dgp_pkg::*;
(
  input  wire dgp_first_pins_s         first_pins_o,
  input  wire dgp_second_pins_s        second_pins_o,
  input  wire logic [FIRST_WIDTH-1:0]  ext_first_i,
  input  wire logic [SECOND_WIDTH-1:0] ext_second_i,
  output logic      [FIRST_WIDTH-1:0]  first_pin_o,
  output logic      [SECOND_WIDTH-1:0] second_pin_o
);
  // a driven pad follows its driver, a released one the outside world
  always_comb begin
    for (int i = 0; i < FIRST_WIDTH; i++) begin
      first_pin_o[i] = first_pins_o.oe_n[i] ? ext_first_i[i]
                                            : first_pins_o.out[i];
    end
    for (int i = 0; i < SECOND_WIDTH; i++) begin
      second_pin_o[i] = second_pins_o.oe_n[i] ? ext_second_i[i]
                                              : second_pins_o.out[i];
    end
  end
endmodule : dgp_pad_model

// ---- verif/testbench.sv ----
// testbench: register, pin, lcd, peripheral and standby checks
// assumes wishbone ack one cycle after the request is taken
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR %0t: got %h want %h", $time, a, b); \
  end end
module testbench
  import dgp_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rmw = 0, stby = 0;
  logic [7:0]  adr = 0, e;
  logic [31:0] dat = 0, r, l, seed = 32'hdecf827d;
  logic [31:0] wb_dat_o, exp_q[$];
  logic        wb_ack_o;
  dgp_periph_s per = '0;
  dgp_first_pins_s  first_pins_o;
  dgp_second_pins_s second_pins_o;
  logic [7:0] ext1 = 0, pin1, first_in_o;
  logic [2:0] ext2 = 0, pin2, second_in_o;
  int num_errors = 0, comparisons = 0;
  always #20 clk_i = ~clk_i;
  dgp_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .rmw_read_i(rmw), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .standby_i(stby), .periph_i(per), .first_pin_i(pin1),
    .second_pin_i(pin2), .first_pins_o(first_pins_o),
    .second_pins_o(second_pins_o), .first_in_o(first_in_o),
    .second_in_o(second_in_o));
  dgp_pad_model pads (.first_pins_o(first_pins_o),
    .second_pins_o(second_pins_o), .ext_first_i(ext1), .ext_second_i(ext2),
    .first_pin_o(pin1), .second_pin_o(pin2));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // called at a rising edge; drives there, holds until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("ERROR %0t: bus request not answered", $time);
      summarize();
    end
    cyc <= 0; stb <= 0; we <= 0; rmw <= 0;
    @(posedge clk_i);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic m);
    exp_q.push_back(x);
    rmw <= m;
    bus(0, a, 0);
  endtask : rd
  // read data is judged here, in the order the reads were issued
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("ERROR %0t: read answer with nothing expected", $time);
      end
      else `CHK(wb_dat_o, exp_q.pop_front())
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    `CHK(first_pins_o.oe_n, 8'hff)
    rd(ADDR_FIRST_DIR, 0, 0);
    rd(ADDR_SECOND_DIR, 0, 0);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed); r = seed;
      seed = lfsr(seed); l = seed;
      seed = lfsr(seed); e = seed[7:0]; ext1 <= e;
      bus(1, ADDR_FIRST_DIR, r);
      bus(1, ADDR_FIRST_LATCH, l);
      `CHK(first_pins_o.oe_n, ~r[7:0])
      `CHK(first_pins_o.out & r[7:0], l[7:0] & r[7:0])
      rd(ADDR_FIRST_LATCH, {24'h0, (l[7:0] & r[7:0]) | (e & ~r[7:0])},
         0);
      rd(ADDR_FIRST_LATCH, {24'h0, l[7:0]}, 1);
    end
    bus(1, ADDR_SECOND_DIR, 32'hff);
    bus(1, ADDR_SECOND_LATCH, 32'hff);
    `CHK(second_pins_o.oe_n, 3'b100)
    `CHK(second_pins_o.out[1:0], 2'b11)
    rd(ADDR_SECOND_DIR, 32'h7, 0);
    rd(ADDR_SECOND_LATCH, 32'h7, 1);
    bus(1, ADDR_FIRST_DIR, 0);
    ext1 <= 8'h00; per.per_oe <= 8'h20; per.per_out <= 8'h20;
    @(posedge clk_i);
    `CHK(first_pins_o.oe_n[5], 1'b0)
    rd(ADDR_FIRST_LATCH, 32'h20, 0);
    per.per_oe <= 0; per.seg <= 8'h01;
    bus(1, ADDR_LCD_SELECT, 32'h1);
    bus(1, ADDR_CONTROL, 32'h401);
    `CHK({first_pins_o.oe_n[0], first_pins_o.out[0]}, 2'b01)
    bus(1, ADDR_LCD_SELECT, 0);
    `CHK(first_pins_o.oe_n[0], 1'b1)
    bus(1, ADDR_FIRST_DIR, 32'hff);
    bus(1, ADDR_FIRST_LATCH, 32'ha5);
    bus(1, ADDR_CONTROL, 32'h402);
    ext1 <= 8'hff; stby <= 1;
    @(posedge clk_i);
    `CHK(first_pins_o.oe_n, 8'hff)
    `CHK(second_pins_o.oe_n, 3'b111)
    `CHK(first_in_o, 8'h00)
    bus(1, ADDR_CONTROL, 32'h400);
    `CHK(first_pins_o, {8'ha5, 8'h00})
    stby <= 0;
    bus(1, 8'h20, 32'hff);
    rd(8'h20, 0, 0);
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule : testbench
